//--- src/pbis_pkg.sv
// constants and types shared by the peripheral interrupt synchronizer
package pbis_pkg;
  // register block placement and word offsets
  localparam logic [23:0] BLOCK_BASE = 24'h307f80;
  localparam logic [23:0] CFG_OFS = 24'h307f80;
  localparam logic [23:0] TEST_OFS = 24'h307f90;
  localparam logic [23:0] PEND_OFS = 24'h307fa0;
  // 128-byte block: upper address bits above bit 6 select it
  localparam int BLOCK_LSB = 7;
  localparam int WORD_LSB = 2;

  // configuration fields, as data-bus bit indices (big-endian bit 0 = 31)
  localparam int CFG_STOP_BIT = 31;
  localparam int CFG_MUX_HI = 30;
  localparam int CFG_MUX_LO = 29;
  localparam int CFG_HALF_SPEED_SELECT_BIT = 28;
  // byte lane that carries configuration bits 0 to 3
  localparam int CFG_LANE = 3;

  // reset values
  localparam logic CFG_STOP_RST = 1'b0;
  localparam logic [1:0] CFG_MUX_RST = 2'b00;
  localparam logic CFG_HALF_SPEED_SELECT_RST = 1'b1;
  localparam logic [31:0] TEST_RST = 32'h0000_0000;
  localparam logic [31:0] PEND_RST = 32'h0000_0000;
  localparam logic [7:0] GROUP_RST = 8'h00;

  // interrupt geometry
  localparam int NUM_LINES = 8;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_LEVELS = 32;
  localparam int SUMMARY_LEVEL = 7;

  // bus answer state
  typedef enum logic [1:0] {
    PBIS_IDLE = 2'b01,
    PBIS_ANSWER = 2'b10
  } pbis_bus_state_t;
endpackage : pbis_pkg

//--- src/pbis_seq_if.sv
// sequencing signals between the config block, sequencer and latches
`timescale 1ns/1ns
interface pbis_seq_if;
  logic stop;
  logic half_speed_select;
  logic [1:0] mux;
  logic tick;
  logic [1:0] grp;
  modport seq (input stop, input half_speed_select, input mux, output tick,
    output grp);
  modport lat (input tick, input grp, input mux);
endinterface : pbis_seq_if

//--- src/pbis_seq.sv
// peripheral clock enable divider and group select sequencer
`timescale 1ns/1ns
module pbis_seq (
  input wire logic clk,
  input wire logic rst,
  pbis_seq_if.seq s
);
  logic half_r;
  logic half_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [1:0] grp_r;
  logic [1:0] grp_nxt;

  // stop halts the ticks and clears the half-speed phase; half speed ticks every other cycle
  always_comb begin
    half_nxt = 1'b0;
    tick_nxt = 1'b0;
    grp_nxt = grp_r;
    if (!s.stop) begin
      half_nxt = s.half_speed_select ? ~half_r : 1'b0;
      tick_nxt = !s.half_speed_select || half_r;
    end
    // a smaller mode written mid-sequence snaps back to group 0
    if (grp_r > s.mux) begin
      grp_nxt = 2'b00;
    end else if (tick_r) begin
      grp_nxt = (grp_r == s.mux) ? 2'b00 : grp_r + 2'b01;
    end
  end

  // held at group 0 with no ticks while reset is high
  always_ff @(posedge clk) begin
    if (rst) begin
      half_r <= 1'b0;
      tick_r <= 1'b0;
      grp_r <= 2'b00;
    end else begin
      half_r <= half_nxt;
      tick_r <= tick_nxt;
      grp_r <= grp_nxt;
    end
  end

  assign s.tick = tick_r;
  assign s.grp = grp_r;
endmodule : pbis_seq

//--- src/pbis_grp_latch.sv
// one eight-level group of the pending latch
`timescale 1ns/1ns
module pbis_grp_latch #(
  parameter logic [1:0] GROUP = 2'b00
) (
  input wire logic clk,
  input wire logic rst,
  pbis_seq_if.lat s,
  input wire logic [7:0] lines,
  output logic [7:0] lvl
);
  logic [7:0] lvl_r;
  logic [7:0] lvl_nxt;

  // sample only in this group's phase; groups beyond the mode stay 0
  always_comb begin
    lvl_nxt = lvl_r;
    if (GROUP > s.mux) begin
      lvl_nxt = pbis_pkg::GROUP_RST;
    end else if (s.tick && s.grp == GROUP) begin
      lvl_nxt = lines;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_r <= pbis_pkg::GROUP_RST;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  assign lvl = lvl_r;
endmodule : pbis_grp_latch

//--- src/pbis_top.sv
// peripheral bus interrupt synchronizer with its register bank
`timescale 1ns/1ns
module pbis_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REQ,
  input wire logic WR,
  input wire logic [23:0] ADDR,
  input wire logic [3:0] BE,
  input wire logic SUPV,
  input wire logic TEST_MODE,
  input wire logic [31:0] WDATA,
  input wire logic [7:0] IRQ_LINES,
  output logic [31:0] RDATA,
  output logic ACK,
  output logic DERR,
  output logic [1:0] GROUP_SEL,
  output logic PBUS_CLK_EN,
  output logic [31:0] LEVEL_REQ
);
  pbis_seq_if sif ();

  logic stop_r;
  logic stop_nxt;
  logic [1:0] mux_r;
  logic [1:0] mux_nxt;
  logic half_speed_select_r;
  logic half_speed_select_nxt;
  logic zero_seen_r;
  logic zero_seen_nxt;
  logic [31:0] test_r;
  logic [31:0] test_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  logic derr_r;
  logic derr_nxt;
  logic [31:0] lreq_r;
  logic [31:0] lreq_nxt;
  pbis_pkg::pbis_bus_state_t st_r;
  pbis_pkg::pbis_bus_state_t st_nxt;
  logic [31:0] levels;
  logic [31:0] pend_word;
  logic [31:0] cfg_word;
  logic [7:0] grp_lvl [pbis_pkg::NUM_GROUPS];
  logic in_block;
  logic cfg_hit;
  logic test_hit;
  logic pend_hit;
  logic cfg_lane;

  assign sif.stop = stop_r;
  assign sif.half_speed_select = half_speed_select_r;
  assign sif.mux = mux_r;

  pbis_seq u_seq (
    .clk(SYS_CLK),
    .rst(RST),
    .s(sif)
  );

  // one latch per eight-level group
  generate
    for (genvar g = 0; g < pbis_pkg::NUM_GROUPS; g++) begin : g_lat
      pbis_grp_latch #(.GROUP(2'(g))) u_lat (
        .clk(SYS_CLK),
        .rst(RST),
        .s(sif),
        .lines(IRQ_LINES),
        .lvl(grp_lvl[g])
      );
    end
  endgenerate

  // level vector indexed by level number, summary folded into level 7
  always_comb begin
    levels = '0;
    for (int g = 0; g < pbis_pkg::NUM_GROUPS; g++) begin
      levels[g*8 +: 8] = grp_lvl[g];
    end
    levels[pbis_pkg::SUMMARY_LEVEL] =
      |levels[pbis_pkg::NUM_LEVELS-1:pbis_pkg::SUMMARY_LEVEL];
  end

  // big-endian numbering: level n lands on data bit 31-n
  always_comb begin
    pend_word = '0;
    for (int n = 0; n < pbis_pkg::NUM_LEVELS; n++) begin
      pend_word[31-n] = levels[n];
    end
  end

  // config readback, unimplemented bits forced low
  always_comb begin
    cfg_word = '0;
    cfg_word[pbis_pkg::CFG_STOP_BIT] = stop_r;
    cfg_word[pbis_pkg::CFG_MUX_HI:pbis_pkg::CFG_MUX_LO] = mux_r;
    cfg_word[pbis_pkg::CFG_HALF_SPEED_SELECT_BIT] = half_speed_select_r;
  end

  // decode: privilege failures answer like a reserved word
  assign in_block = ADDR[23:pbis_pkg::BLOCK_LSB] ==
    pbis_pkg::BLOCK_BASE[23:pbis_pkg::BLOCK_LSB];
  assign cfg_hit = SUPV && ADDR[23:pbis_pkg::WORD_LSB] ==
    pbis_pkg::CFG_OFS[23:pbis_pkg::WORD_LSB];
  assign test_hit = SUPV && TEST_MODE && ADDR[23:pbis_pkg::WORD_LSB] ==
    pbis_pkg::TEST_OFS[23:pbis_pkg::WORD_LSB];
  assign pend_hit = SUPV && ADDR[23:pbis_pkg::WORD_LSB] ==
    pbis_pkg::PEND_OFS[23:pbis_pkg::WORD_LSB];
  assign cfg_lane = BE[pbis_pkg::CFG_LANE];

  // register bank and bus answer; accesses outside the block are not ours
  always_comb begin
    stop_nxt = stop_r;
    mux_nxt = mux_r;
    half_speed_select_nxt = half_speed_select_r;
    zero_seen_nxt = zero_seen_r;
    test_nxt = test_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    derr_nxt = 1'b0;
    st_nxt = pbis_pkg::PBIS_IDLE;
    unique case (st_r)
      pbis_pkg::PBIS_IDLE: begin
        if (REQ && in_block) begin
          st_nxt = pbis_pkg::PBIS_ANSWER;
          ack_nxt = 1'b1;
          if (!(cfg_hit || test_hit || pend_hit)) begin
            derr_nxt = 1'b1;
          end else if (WR) begin
            if (cfg_hit && cfg_lane) begin
              stop_nxt = WDATA[pbis_pkg::CFG_STOP_BIT];
              mux_nxt = WDATA[pbis_pkg::CFG_MUX_HI:
                pbis_pkg::CFG_MUX_LO];
              if (!WDATA[pbis_pkg::CFG_HALF_SPEED_SELECT_BIT]) begin
                half_speed_select_nxt = 1'b0;
                zero_seen_nxt = 1'b1;
              end else if (!zero_seen_r) begin
                half_speed_select_nxt = 1'b1;
              end
            end
            if (test_hit) begin
              for (int b = 0; b < 4; b++) begin
                if (BE[b]) begin
                  test_nxt[b*8 +: 8] = WDATA[b*8 +: 8];
                end
              end
            end
            // a pending write is acknowledged and discarded
          end else begin
            // partial reads return the full word; lanes pick bytes
            if (cfg_hit) begin
              rdata_nxt = cfg_word;
            end else if (test_hit) begin
              rdata_nxt = test_r;
            end else begin
              rdata_nxt = pend_word;
            end
          end
        end
      end
      pbis_pkg::PBIS_ANSWER: begin
        // one idle cycle between answers keeps ACK a clean pulse
        st_nxt = pbis_pkg::PBIS_IDLE;
      end
      default: begin
        st_nxt = pbis_pkg::PBIS_IDLE;
      end
    endcase
  end

  // forwarded levels track pending every cycle
  always_comb begin
    lreq_nxt = levels;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stop_r <= pbis_pkg::CFG_STOP_RST;
      mux_r <= pbis_pkg::CFG_MUX_RST;
      half_speed_select_r <= pbis_pkg::CFG_HALF_SPEED_SELECT_RST;
      zero_seen_r <= 1'b0;
      test_r <= pbis_pkg::TEST_RST;
      rdata_r <= '0;
      ack_r <= 1'b0;
      derr_r <= 1'b0;
      lreq_r <= pbis_pkg::PEND_RST;
      st_r <= pbis_pkg::PBIS_IDLE;
    end else begin
      stop_r <= stop_nxt;
      mux_r <= mux_nxt;
      half_speed_select_r <= half_speed_select_nxt;
      zero_seen_r <= zero_seen_nxt;
      test_r <= test_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      derr_r <= derr_nxt;
      lreq_r <= lreq_nxt;
      st_r <= st_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign ACK = ack_r;
  assign DERR = derr_r;
  assign LEVEL_REQ = lreq_r;
  assign GROUP_SEL = sif.grp; // flop inside the sequencer
  assign PBUS_CLK_EN = sif.tick; // flop inside the sequencer
endmodule : pbis_top

//--- verif/pbis_src.sv
// model of the peripheral interrupt sources on the eight request lines
`timescale 1ns/1ns
module pbis_src (
  input wire logic [1:0] group_sel,
  input wire logic [31:0] levels,
  output logic [7:0] lines
);
  // each source drives its line only in the phase naming its group
  assign lines = levels[8 * group_sel +: 8];
endmodule : pbis_src

//--- verif/pbis_assertions.sv
// port-level assertions for the interrupt synchronizer
`timescale 1ns/1ns
module pbis_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REQ,
  input wire logic WR,
  input wire logic [23:0] ADDR,
  input wire logic SUPV,
  input wire logic [31:0] RDATA,
  input wire logic ACK,
  input wire logic DERR,
  input wire logic [1:0] GROUP_SEL,
  input wire logic PBUS_CLK_EN,
  input wire logic [31:0] LEVEL_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // a request only counts when no answer stands in the same cycle
  logic go;
  assign go = REQ && !ACK;
  a_derr_with_ack: assert property (DERR |-> ACK)
    else $error("data error without ack");
  a_rsvd_word: assert property (go && ADDR[23:5] == 19'h183fc &&
    ADDR[3:2] != 2'b00 |=> ACK && DERR) else $error("reserved no error");
  a_cfg_user: assert property (go && ADDR[23:2] == 22'h0c1fe0 &&
    !SUPV |=> ACK && DERR) else $error("user config access accepted");
  a_pend_user: assert property (go && ADDR[23:2] == 22'h0c1fe8 &&
    !SUPV |=> ACK && DERR) else $error("user pending access accepted");
  a_cfg_upper: assert property (go && !WR && SUPV &&
    ADDR[23:2] == 22'h0c1fe0 |=> ACK && !DERR && RDATA[27:0] == 28'h0)
    else $error("config upper bits not zero");
  a_outside_quiet: assert property (REQ &&
    ADDR[23:7] != 17'h060ff |=> !ACK) else $error("outside access acked");
  a_level_summary: assert property (|LEVEL_REQ[31:7] |->
    LEVEL_REQ[7]) else $error("summary level missing");
  a_group_hold: assert property (!PBUS_CLK_EN |=>
    $stable(GROUP_SEL)) else $error("group moved without clock");
  a_group_step: assert property (PBUS_CLK_EN |=> GROUP_SEL == 2'b00 ||
    GROUP_SEL == $past(GROUP_SEL) + 2'b01) else $error("group skipped");
endmodule : pbis_chk

bind pbis_top pbis_chk u_chk (.SYS_CLK, .RST, .REQ, .WR, .ADDR, .SUPV,
  .RDATA, .ACK, .DERR, .GROUP_SEL, .PBUS_CLK_EN, .LEVEL_REQ);

//--- verif/test_pbis.sv
// self-checking bench for the interrupt synchronizer
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_peripheral_bus_irq_synchronizer;
  logic SYS_CLK, RST, REQ, WR, SUPV, TEST_MODE, ACK, DERR, PBUS_CLK_EN;
  logic acked, er;
  logic [23:0] ADDR;
  logic [3:0] BE;
  logic [31:0] WDATA, RDATA, LEVEL_REQ, levels, rd;
  logic [7:0] IRQ_LINES;
  logic [1:0] GROUP_SEL;
  logic [4:0] cnt;
  int num_errors, samples_checked;
  pbis_top u_dut (.SYS_CLK, .RST, .REQ, .WR, .ADDR, .BE, .SUPV, .TEST_MODE,
    .WDATA, .IRQ_LINES, .RDATA, .ACK, .DERR, .GROUP_SEL, .PBUS_CLK_EN,
    .LEVEL_REQ);
  pbis_src u_src (.group_sel(GROUP_SEL), .levels(levels), .lines(IRQ_LINES));
  // 125 mhz system clock
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // one register access; request held until the ack edge is sampled
  task automatic acc(input logic w, input logic [23:0] a,
      input logic [31:0] d, input logic s, input logic t);
    int n;
    @(posedge SYS_CLK);
    REQ <= 1'b1;
    WR <= w;
    ADDR <= a;
    WDATA <= d;
    SUPV <= s;
    TEST_MODE <= t;
    n = 0;
    acked = 1'b0;
    while (!acked && n < 6) begin
      @(posedge SYS_CLK);
      acked = (ACK === 1'b1);
      n++;
    end
    rd = RDATA;
    er = DERR;
    REQ <= 1'b0;
    // an in-block access that never answers ends the run
    if (!acked && a[23:7] == 17'h060ff) begin
      `CHK("ack", 1'b1, acked)
      summarize();
    end
  endtask : acc
  task automatic count_en();
    repeat (2) @(posedge SYS_CLK);
    cnt = 5'd0;
    repeat (16) begin
      @(posedge SYS_CLK);
      cnt = cnt + {4'h0, PBUS_CLK_EN};
    end
  endtask : count_en
  task automatic t_reset();
    acc(1'b0, 24'h307f80, 32'h0, 1'b1, 1'b0);
    `CHK("cfg reset", 32'h1000_0000, rd)
    acc(1'b0, 24'h307fa0, 32'h0, 1'b1, 1'b0);
    `CHK("pend reset", 32'h0, rd)
    // half speed after reset: one enable every other cycle
    count_en();
    `CHK("half rate", 5'd8, cnt)
  endtask : t_reset
  task automatic t_errors();
    logic [23:0] bad [6] = '{24'h307f84, 24'h307f88, 24'h307f8c,
      24'h307f94, 24'h307f9c, 24'h307fa4};
    foreach (bad[i]) begin
      acc(1'b0, bad[i], 32'h0, 1'b1, 1'b1);
      `CHK("rsvd derr", 1'b1, er)
    end
    acc(1'b1, 24'h307f80, 32'h8000_0000, 1'b0, 1'b0);
    `CHK("user cfg", 1'b1, er)
    acc(1'b0, 24'h307fa0, 32'h0, 1'b0, 1'b1);
    `CHK("user pend", 1'b1, er)
    acc(1'b0, 24'h307f90, 32'h0, 1'b1, 1'b0);
    `CHK("test no mode", 1'b1, er)
    acc(1'b0, 24'h307f90, 32'h0, 1'b1, 1'b1);
    `CHK("test mode", 1'b0, er)
    acc(1'b1, 24'h307f90, 32'h5a5a_a5a5, 1'b1, 1'b1);
    acc(1'b0, 24'h307f90, 32'h0, 1'b1, 1'b1);
    `CHK("test rw", 32'h5a5a_a5a5, rd)
    // config bits live in the top lane; without it the write is dropped
    BE <= 4'h7;
    acc(1'b1, 24'h307f80, 32'h8000_0000, 1'b1, 1'b0);
    BE <= 4'hf;
    `CHK("lane derr", 1'b0, er)
    acc(1'b0, 24'h307f00, 32'h0, 1'b1, 1'b0);
    `CHK("outside", 1'b0, acked)
    acc(1'b0, 24'h307f80, 32'h0, 1'b1, 1'b0);
    `CHK("cfg kept", 32'h1000_0000, rd)
  endtask : t_errors
  task automatic t_half_speed_select();
    logic [31:0] wv [3] = '{32'h1fff_ffff, 32'h0, 32'h1000_0000};
    logic [31:0] ev [3] = '{32'h1000_0000, 32'h0, 32'h0};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 24'h307f80, wv[i], 1'b1, 1'b0);
      acc(1'b0, 24'h307f80, 32'h0, 1'b1, 1'b0);
      `CHK("half speed", ev[i], rd)
    end
  endtask : t_half_speed_select
  // levels 0, 13, 22 and 31 seen through each multiplex depth
  task automatic t_levels();
    logic [31:0] keep, ex, pe;
    levels <= 32'h8040_2001;
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, 24'h307f80, {1'b0, m[1:0], 29'h0}, 1'b1, 1'b0);
      repeat (24) @(posedge SYS_CLK);
      keep = (m == 3) ? 32'hffff_ffff : ((32'h1 << (8 * m + 8)) - 32'h1);
      ex = levels & keep;
      ex[7] = |ex[31:7];
      pe = {<<{ex}};
      `CHK("forwarded", ex, LEVEL_REQ)
      acc(1'b0, 24'h307fa0, 32'h0, 1'b1, 1'b0);
      `CHK("pending", pe, rd)
    end
    acc(1'b1, 24'h307fa0, 32'h0, 1'b1, 1'b0);
    acc(1'b0, 24'h307fa0, 32'h0, 1'b1, 1'b0);
    `CHK("pend write", pe, rd)
  endtask : t_levels
  // sources go quiet first, since stopping strands pending requests
  task automatic t_stop();
    levels <= 32'h0;
    acc(1'b1, 24'h307f80, 32'h8000_0000, 1'b1, 1'b0);
    count_en();
    `CHK("stopped", 5'd0, cnt)
    acc(1'b1, 24'h307f80, 32'h0, 1'b1, 1'b0);
    count_en();
    `CHK("running", 5'd16, cnt)
  endtask : t_stop
  // reset, then the scenarios in order
  initial begin
    {RST, REQ, WR, SUPV, TEST_MODE} = 5'h10;
    ADDR = 24'h0;
    BE = 4'hf;
    WDATA = 32'h0;
    levels = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_reset();
    t_errors();
    t_half_speed_select();
    t_levels();
    t_stop();
    summarize();
  end
endmodule : test_peripheral_bus_irq_synchronizer
